//--- pmd_code_mem.sv
// Purpose: Output code storage with one write port and two registered reads
// Assumes: Addresses below DEPTH only; callers guard the range
// Notes:   Cleared by reset so every code starts at zero

`timescale 1ns/1ps
`default_nettype none

module pmd_code_mem #(
  parameter int DEPTH  = 20,
  parameter int WIDTH  = 12,
  parameter int AW     = 5
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddrA,
  output var  logic [WIDTH-1:0] rdDataA_q,
  input  wire logic [AW-1:0]    rdAddrB,
  output var  logic [WIDTH-1:0] rdDataB_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdDataA_q <= '0;
      rdDataB_q <= '0;
    end else begin
      rdDataA_q <= mem_q[rdAddrA];
      rdDataB_q <= mem_q[rdAddrB];
    end
  end

endmodule : pmd_code_mem

`default_nettype wire

//--- pmd_host_model.sv
// Purpose: Host side of the register bus
// Assumes: Caller starts each access after a clock edge
// Notes:   Released lines show the inverse, never a stale value
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model (
  input  wire logic        mclk,
  input  wire logic        regRValid_q,
  input  wire logic [15:0] regRData_q,
  output var  logic [7:0]  regAddr,
  output var  logic        regWrite,
  output var  logic        regRead,
  output var  logic [15:0] regWData
);
  int lost;
  initial begin
    lost = 0;
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWData = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    for (n = 0; n < 4 && !regRValid_q; n++) begin
      @(posedge mclk);
      #1;
    end
    if (!regRValid_q) lost++;
    d = regRData_q;
  endtask : rd
endmodule : pmd_host_model
`default_nettype wire

//--- pmd_pkg.sv
// Purpose: Shared constants and types for the port mode and data registers
// Assumes: Register addresses are 8-bit word addresses, one 16-bit word each
// Notes:   Conversion result window placement is local to this block

package pmd_pkg;

  localparam int NUM_PORTS = 20;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int CODE_W    = 12;
  localparam int PORT_W    = 5;

  // Register windows, one word per port
  localparam logic [7:0] CFG_BASE = 8'h20;
  localparam logic [7:0] ADC_BASE = 8'h40;
  localparam logic [7:0] DAC_BASE = 8'h60;
  localparam logic [7:0] PORT_SPAN = 8'h14;

  // Configuration word field positions
  localparam int FUNC_SEL_LSB = 12;
  localparam int FUNC_SEL_W   = 4;
  localparam int INVERT_BIT   = 11;
  localparam int REF_BIT      = 11;
  localparam int SPAN_LSB     = 8;
  localparam int SPAN_W       = 3;
  localparam int AVG_LSB      = 5;
  localparam int AVG_W        = 3;
  localparam int ASSOC_LSB    = 0;
  localparam int ASSOC_W      = 5;

  // Reset values, forced zero code and sign flip mask
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [11:0] ZERO_CODE  = 12'h000;
  localparam logic [11:0] SIGN_FLIP  = 12'h800;

  typedef enum logic [3:0] {
    MODE_HIGHZ      = 4'b0000,
    MODE_GPI        = 4'b0001,
    MODE_XLATE_BIDI = 4'b0010,
    MODE_GPO_REG    = 4'b0011,
    MODE_GPO_PATH   = 4'b0100,
    MODE_DAC        = 4'b0101,
    MODE_DAC_MON    = 4'b0110,
    MODE_ADC_SE     = 4'b0111,
    MODE_ADC_DPOS   = 4'b1000,
    MODE_ADC_DNEG   = 4'b1001,
    MODE_DAC_PSEUDO = 4'b1010,
    MODE_SW_GPI     = 4'b1011,
    MODE_SW_REG     = 4'b1100
  } pmd_mode_type;

  // Decoded port function, zero in fields the mode does not use
  typedef struct packed {
    logic [3:0] functionSelect;
    logic       invertFlag;
    logic       referenceChoice;
    logic [2:0] span;
    logic [2:0] averagingCount;
    logic [4:0] assocPort;
    logic       adcOn;
    logic       dacOn;
    logic       legal;
  } pmd_ctl_type;

  // One finished conversion from the converter sequencer
  typedef struct packed {
    logic [4:0]  port;
    logic [11:0] code;
  } pmd_sample_type;

endpackage : pmd_pkg

//--- pmd_port_decode.sv
// Purpose: Decode one port configuration word into a registered control set
// Assumes: Configuration word comes from a register on the same clock
// Notes:   Unused parameter fields are forced to zero here, not in storage

`timescale 1ns/1ps
`default_nettype none

module pmd_port_decode (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic [15:0]          cfgWord,
  output var  pmd_pkg::pmd_ctl_type ctl_q
);
  import pmd_pkg::*;

  wire logic [3:0] funcSel   = cfgWord[FUNC_SEL_LSB +: FUNC_SEL_W];
  wire logic [11:0] funcParm = cfgWord[11:0];

  wire logic usesInvert = (funcSel == MODE_GPO_PATH) || (funcSel == MODE_SW_GPI);
  wire logic usesRef    = (funcSel >= MODE_DAC_MON) && (funcSel <= MODE_DAC_PSEUDO);
  wire logic usesSpan   = (funcSel >= MODE_DAC) && (funcSel <= MODE_DAC_PSEUDO);
  wire logic usesAvg    = (funcSel == MODE_ADC_SE) || (funcSel == MODE_ADC_DPOS);
  wire logic usesAssoc  = (funcSel == MODE_GPO_PATH) || (funcSel == MODE_ADC_DPOS)
                       || (funcSel == MODE_SW_GPI);
  wire logic adcMode    = (funcSel >= MODE_DAC_MON) && (funcSel <= MODE_DAC_PSEUDO);
  // GPO modes take their high level from the DAC as well
  wire logic dacMode    = (funcSel == MODE_GPO_REG) || (funcSel == MODE_GPO_PATH)
                       || (funcSel == MODE_DAC) || (funcSel == MODE_DAC_MON)
                       || (funcSel == MODE_DAC_PSEUDO);
  wire logic isLegal    = (funcSel <= MODE_SW_REG);

  pmd_ctl_type ctl_d;
  always_comb begin
    ctl_d                 = '0;
    ctl_d.functionSelect  = funcSel;
    ctl_d.invertFlag      = usesInvert & funcParm[INVERT_BIT];
    ctl_d.referenceChoice = usesRef & funcParm[REF_BIT];
    ctl_d.span            = usesSpan ? funcParm[SPAN_LSB +: SPAN_W] : 3'h0;
    ctl_d.averagingCount  = usesAvg ? funcParm[AVG_LSB +: AVG_W] : 3'h0;
    ctl_d.assocPort       = usesAssoc ? funcParm[ASSOC_LSB +: ASSOC_W] : 5'h00;
    ctl_d.adcOn           = adcMode;
    ctl_d.dacOn           = dacMode;
    ctl_d.legal           = isLegal;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

endmodule : pmd_port_decode

`default_nettype wire

//--- pmd_port_regs.sv
// Purpose: Port function, conversion result and output code registers
// Assumes: Serial front end, converter and DAC scanner all run on mclk
// Notes:   Reads answer two cycles after the strobe; writes take effect next edge
//
// How it works
// - Bits 15:12 of each configuration word pick the port function, bits 11:0 are its parameters.
// - Codes 0 to 3 give high impedance, digital input, bidirectional translator and driven output.
// - Code 5 makes an analog output whose span comes from bits 10:8.
// - Code 6 is an analog output that is also converted, using reference bit 11 and span bits 10:8.
// - Code 7 is a single-ended input with reference bit, span and averaging count in bits 7:5.
// - Code 8 is the positive differential input with reference, span, averaging and associated port.
// - Code 9 is the negative differential input using only reference bit and span.
// - Every port has a read-only 12-bit conversion result holding its latest conversion taken while the port is in modes 6 to 10.
// - Results of ports in modes 6 and 7 read as unsigned straight binary.
// - Results of a port in mode 8 read as two's complement.
// - Results of a port in mode 9 or 10 always read as zero.
// - Every port has a readable and writable 12-bit straight binary output code.

`timescale 1ns/1ps
`default_nettype none

module pmd_port_regs (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              regAddr,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  input  wire logic [15:0]             regWData,
  output var  logic [15:0]             regRData_q,
  output var  logic                    regRValid_q,
  input  wire logic                    adcValid,
  input  wire pmd_pkg::pmd_sample_type adcSample,
  input  wire logic [4:0]              dacScanPort,
  output var  logic [11:0]             dacScanCode_q,
  output var  pmd_pkg::pmd_ctl_type    portCtl_q [pmd_pkg::NUM_PORTS]
);
  import pmd_pkg::*;

  // Address decode
  wire logic [7:0] cfgOff = regAddr - CFG_BASE;
  wire logic [7:0] adcOff = regAddr - ADC_BASE;
  wire logic [7:0] dacOff = regAddr - DAC_BASE;
  wire logic       cfgHit = (regAddr >= CFG_BASE) && (cfgOff < PORT_SPAN);
  wire logic       adcHit = (regAddr >= ADC_BASE) && (adcOff < PORT_SPAN);
  wire logic       dacHit = (regAddr >= DAC_BASE) && (dacOff < PORT_SPAN);
  wire logic [4:0] cfgIdx = cfgOff[4:0];
  wire logic [4:0] adcIdx = adcOff[4:0];
  wire logic [4:0] dacIdx = dacOff[4:0];

  wire logic cfgWrite = regWrite && cfgHit;
  // Result window is read-only; writes there are dropped
  wire logic dacWrite = regWrite && dacHit;

  // Configuration words, stored whole as written
  logic [15:0] cfg_q [NUM_PORTS];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (cfgWrite) begin
      cfg_q[cfgIdx] <= regWData;
    end
  end

  // Per-port function decode
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      pmd_port_decode u_decode (
        .mclk    (mclk),
        .reset_n (reset_n),
        .cfgWord (cfg_q[gp]),
        .ctl_q   (portCtl_q[gp])
      );
    end
  endgenerate

  // Conversion results
  wire logic       sampleInRange = adcValid && (adcSample.port < NUM_PORTS[4:0]);
  wire logic [3:0] sampleMode    = cfg_q[adcSample.port][FUNC_SEL_LSB +: FUNC_SEL_W];
  wire logic       sampleNegIn   = (sampleMode == MODE_ADC_DNEG)
                                || (sampleMode == MODE_DAC_PSEUDO);
  wire logic       sampleDiffPos = (sampleMode == MODE_ADC_DPOS);
  wire logic       sampleTaken   = (sampleMode >= MODE_DAC_MON) && (sampleMode <= MODE_DAC_PSEUDO);
  // Converter gives offset binary; flipping the top bit yields two's complement
  wire logic [11:0] sampleFmt =
      sampleNegIn   ? ZERO_CODE :
      sampleDiffPos ? (adcSample.code ^ SIGN_FLIP) :
                      adcSample.code;

  logic [11:0] adc_q [NUM_PORTS];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        adc_q[i] <= CODE_RESET;
      end
    end else if (sampleInRange && sampleTaken) begin
      adc_q[adcSample.port] <= sampleFmt;
    end
  end

  // Result read forces zero for negative inputs even if stale data remains
  wire logic [3:0] readMode   = cfg_q[adcIdx][FUNC_SEL_LSB +: FUNC_SEL_W];
  wire logic       readNegIn  = (readMode == MODE_ADC_DNEG) || (readMode == MODE_DAC_PSEUDO);
  wire logic [11:0] adcRdVal  = readNegIn ? ZERO_CODE : adc_q[adcIdx];

  // Output codes in their own memory
  wire logic [4:0] dacScanIdx = (dacScanPort < NUM_PORTS[4:0]) ? dacScanPort : 5'h00;
  wire logic [4:0] dacRdIdx   = dacHit ? dacIdx : 5'h00;
  logic [11:0] dacRdData;
  logic [11:0] dacScanData;

  pmd_code_mem #(
    .DEPTH (NUM_PORTS),
    .WIDTH (CODE_W),
    .AW    (PORT_W)
  ) u_code_mem (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .wrEn      (dacWrite),
    .wrAddr    (dacIdx),
    .wrData    (regWData[11:0]),
    .rdAddrA   (dacRdIdx),
    .rdDataA_q (dacRdData),
    .rdAddrB   (dacScanIdx),
    .rdDataB_q (dacScanData)
  );

  // Scan path to the DAC sequencer, one extra flop keeps the output registered
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dacScanCode_q <= CODE_RESET;
    end else begin
      dacScanCode_q <= dacScanData;
    end
  end

  // Read pipeline, stage one: capture word and which window was hit
  wire logic [15:0] stageWord =
      cfgHit ? cfg_q[cfgIdx] :
      adcHit ? {4'h0, adcRdVal} :
               16'h0000;

  logic        rdPend_q;
  logic        rdDac_q;
  logic [15:0] rdWord_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdPend_q <= 1'b0;
      rdDac_q  <= 1'b0;
      rdWord_q <= 16'h0000;
    end else begin
      rdPend_q <= regRead;
      rdDac_q  <= regRead && dacHit;
      rdWord_q <= regRead ? stageWord : 16'h0000;
    end
  end

  // Stage two: memory data has arrived, unmapped reads give zero
  wire logic [15:0] rdFinal = rdDac_q ? {4'h0, dacRdData} : rdWord_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRData_q  <= 16'h0000;
      regRValid_q <= 1'b0;
    end else begin
      regRData_q  <= rdPend_q ? rdFinal : regRData_q;
      regRValid_q <= rdPend_q;
    end
  end

endmodule : pmd_port_regs

`default_nettype wire

//--- pmd_port_regs_monitor.sv
// Purpose: Port register checks at the block ports
// Assumes: Only port 0 decode is watched
// Notes:   Port 0 is cheap to reach from the bench
`timescale 1ns/1ps
`default_nettype none
module pmd_port_regs_monitor
  import pmd_pkg::*;
(
  input wire logic           mclk,
  input wire logic           reset_n,
  input wire logic [7:0]     regAddr,
  input wire logic           regWrite,
  input wire logic           regRead,
  input wire logic [15:0]    regWData,
  input wire logic [15:0]    regRData_q,
  input wire logic           regRValid_q,
  input wire logic           adcValid,
  input wire pmd_sample_type adcSample,
  input wire logic [4:0]     dacScanPort,
  input wire logic [11:0]    dacScanCode_q,
  input wire pmd_ctl_type    portCtl_q [NUM_PORTS]
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pmd_ctl_type c0;
  assign c0 = portCtl_q[0];
  read_answer_a:
    assert property (regRead |-> ##2 regRValid_q) else $error("read not answered");
  valid_cause_a:
    assert property (regRValid_q |-> $past(regRead, 2)) else $error("answer without read");
  data_hold_a:
    assert property (!regRValid_q |-> $stable(regRData_q)) else $error("read data moved");
  upper_zero_a:
    assert property (regRead && regAddr >= ADC_BASE |-> ##2 regRData_q[15:12] == 4'h0)
      else $error("upper bits not zero");
  sel_follow_a:
    assert property (regWrite && regAddr == CFG_BASE && regWData[15:12] < 4'hD
      |-> ##2 c0.functionSelect == $past(regWData[15:12], 2)) else $error("select wrong");
  illegal_code_a:
    assert property (regWrite && regAddr == CFG_BASE && regWData[15:12] >= 4'hD
      |-> ##2 !c0.legal && !c0.adcOn && !c0.dacOn) else $error("illegal code active");
  dac_only_a:
    assert property (c0.functionSelect == MODE_DAC |-> c0.dacOn && !c0.adcOn
      && c0.averagingCount == 3'h0 && !c0.referenceChoice) else $error("mode 5 decode");
  monitor_both_a:
    assert property (c0.functionSelect == MODE_DAC_MON |-> c0.adcOn && c0.dacOn
      && c0.assocPort == 5'h00) else $error("mode 6 decode");
  neg_input_a:
    assert property (c0.functionSelect == MODE_ADC_DNEG |-> c0.averagingCount == 3'h0
      && c0.assocPort == 5'h00 && !c0.invertFlag) else $error("mode 9 decode");
  unused_zero_a:
    assert property (c0.functionSelect < 4'h4 |-> {c0.invertFlag, c0.referenceChoice,
      c0.span, c0.averagingCount, c0.assocPort} == 13'h0000) else $error("stray field");
endmodule : pmd_port_regs_monitor
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the port registers
// Assumes: Host model drives the register bus
// Notes:   The 1 ms settle wait dominates run time
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmd_pkg::*;
  logic           mclk, reset_n, adcValid, regWrite, regRead, regRValid_q;
  logic [7:0]     regAddr;
  logic [15:0]    regWData, regRData_q, rdat;
  pmd_sample_type adcSample;
  logic [4:0]     dacScanPort;
  logic [11:0]    dacScanCode_q;
  pmd_ctl_type    portCtl_q [NUM_PORTS];
  int             mismatches, compares;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  pmd_port_regs pmd_port_regs_i (.mclk, .reset_n, .regAddr, .regWrite, .regRead,
    .regWData, .regRData_q, .regRValid_q, .adcValid, .adcSample, .dacScanPort,
    .dacScanCode_q, .portCtl_q);
  pmd_host_model pmd_host_model_i (.mclk, .regRValid_q, .regRData_q, .regAddr,
    .regWrite, .regRead, .regWData);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    pmd_host_model_i.rd(a, rdat);
    chk(n, e, rdat);
  endtask : rdchk
  task automatic adc(input logic [4:0] p, input logic [11:0] c);
    @(posedge mclk);
    adcValid <= 1'b1;
    adcSample <= {p, c};
    @(posedge mclk);
    adcValid <= 1'b0;
    adcSample <= ~{p, c};
  endtask : adc
  function automatic logic [12:0] fields(input int m, input logic [11:0] w);
    logic i, r, s, a, p;
    i = m == 4 || m == 11;
    r = m >= 6 && m <= 10;
    s = m >= 5 && m <= 10;
    a = m == 7 || m == 8;
    p = m == 4 || m == 8 || m == 11;
    return {w[11] & i, w[11] & r, w[10:8] & {3{s}}, w[7:5] & {3{a}}, w[4:0] & {5{p}}};
  endfunction : fields
  task automatic t_reset;
    rdchk("cfg0", CFG_BASE, CFG_RESET);
    rdchk("code5", DAC_BASE + 8'h05, 16'h0000);
    rdchk("unmapped", 8'h00, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    logic [11:0] w;
    for (int k = 0; k < 2; k++) begin
      w = k ? 12'h4D2 : 12'hB2D; // Two patterns so every field bit toggles
      for (int m = 0; m < 16; m++) begin
        pmd_host_model_i.wr(CFG_BASE, {m[3:0], w});
        rdchk("cfg word", CFG_BASE, {m[3:0], w});
        chk("fields", {3'h0, fields(m, w)}, {3'h0, portCtl_q[0].invertFlag,
          portCtl_q[0].referenceChoice, portCtl_q[0].span, portCtl_q[0].averagingCount,
          portCtl_q[0].assocPort});
        chk("select", {12'h000, m < 13 ? m[3:0] : 4'h0}, {12'h000, m < 13 ?
          portCtl_q[0].functionSelect : {3'h0, portCtl_q[0].legal}});
        chk("flags", {13'h0000, (m >= 6 && m <= 10), ((m >= 3 && m <= 6) || m == 10), (m < 13)},
          {13'h0000, portCtl_q[0].adcOn, portCtl_q[0].dacOn, portCtl_q[0].legal});
      end
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_adc;
    pmd_host_model_i.wr(CFG_BASE + 8'h02, 16'h8103);
    pmd_host_model_i.wr(CFG_BASE + 8'h03, 16'h9100);
    pmd_host_model_i.wr(CFG_BASE + 8'h04, 16'h7100);
    pmd_host_model_i.wr(CFG_BASE + 8'h06, 16'hA100);
    pmd_host_model_i.wr(CFG_BASE + 8'h07, 16'h6100);
    adc(5'h07, 12'hABC);
    rdchk("monitor result", ADC_BASE + 8'h07, 16'h0ABC);
    adc(5'h02, 12'h900);
    rdchk("diff result", ADC_BASE + 8'h02, 16'h0100);
    adc(5'h03, 12'h123);
    rdchk("neg result", ADC_BASE + 8'h03, 16'h0000);
    adc(5'h06, 12'h555);
    rdchk("pseudo result", ADC_BASE + 8'h06, 16'h0000);
    adc(5'h04, 12'h900);
    rdchk("se result", ADC_BASE + 8'h04, 16'h0900);
    pmd_host_model_i.wr(ADC_BASE + 8'h04, 16'h0FFF);
    rdchk("ro result", ADC_BASE + 8'h04, 16'h0900);
    adc(5'h05, 12'h777);
    rdchk("idle result", ADC_BASE + 8'h05, 16'h0000);
    $display("test converter done");
  endtask : t_adc
  task automatic t_dac;
    pmd_host_model_i.wr(DAC_BASE + 8'h13, 16'hFABC);
    rdchk("code19", DAC_BASE + 8'h13, 16'h0ABC);
    repeat (40000) @(posedge mclk);
    pmd_host_model_i.wr(CFG_BASE + 8'h13, 16'h3000);
    @(posedge mclk);
    dacScanPort <= 5'h13;
    repeat (3) @(posedge mclk);
    #1;
    chk("scan code", 16'h0ABC, {4'h0, dacScanCode_q});
    $display("test output code done");
  endtask : t_dac
  task automatic results;
    mismatches += pmd_host_model_i.lost;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    mismatches = 0;
    compares = 0;
    reset_n = 1'b0;
    adcValid = 1'b0;
    adcSample = '0;
    dacScanPort = 5'h00;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_modes;
    t_adc;
    t_dac;
    results;
  end
endmodule : testbench
bind pmd_port_regs pmd_port_regs_monitor pmd_port_regs_monitor_i (.mclk, .reset_n,
  .regAddr, .regWrite, .regRead, .regWData, .regRData_q, .regRValid_q, .adcValid,
  .adcSample, .dacScanPort, .dacScanCode_q, .portCtl_q);
`default_nettype wire
